/* logic/fcc_pkg.sv */
/*
 * Constants for the flash command controller: register map, field
 * positions, command codes, reset values and operation times.
 * Assumes a 125 MHz system clock and 32-bit APB addresses.
 */
package fcc_pkg;
	localparam logic [31:0] FCC_STA_ADDR = 32'hFFFF0E00;
	localparam logic [31:0] FCC_MOD_ADDR = 32'hFFFF0E04;
	localparam logic [31:0] FCC_CMD_ADDR = 32'hFFFF0E08;
	localparam logic [31:0] FCC_DAT_ADDR = 32'hFFFF0E0C;
	localparam logic [31:0] FCC_ADR_ADDR = 32'hFFFF0E10;

	localparam logic [15:0] FCC_STA_RST = 16'h0020;
	localparam logic [15:0] FCC_STA_RD_MASK = 16'h000F;
	localparam logic [6:0] FCC_MOD_RST = 7'h00;
	localparam logic [15:0] FCC_DAT_RST = 16'h0000;

	localparam int FCC_STA_SUCC = 0;
	localparam int FCC_STA_FAIL = 1;
	localparam int FCC_STA_BUSY = 2;
	localparam int FCC_STA_IRQ = 3;
	localparam int FCC_MOD_ABORT = 1;
	localparam int FCC_MOD_EW_EN = 3;
	localparam int FCC_MOD_IRQ_EN = 4;
	localparam int FCC_MOD_LOCK_LO = 5;
	localparam int FCC_MOD_LOCK_HI = 6;
	localparam logic [1:0] FCC_LOCK_KEY = 2'h2;

	localparam logic [15:0] FCC_MASS_KEY_ADR = 16'hFFC3;
	localparam logic [15:0] FCC_MASS_KEY_DAT = 16'h3CFF;

	localparam logic [7:0] FCC_CMD_READ = 8'h01;
	localparam logic [7:0] FCC_CMD_WRITE = 8'h02;
	localparam logic [7:0] FCC_CMD_EWRITE = 8'h03;
	localparam logic [7:0] FCC_CMD_VERIFY = 8'h04;
	localparam logic [7:0] FCC_CMD_PERASE = 8'h05;
	localparam logic [7:0] FCC_CMD_MASS = 8'h06;
	localparam logic [7:0] FCC_CMD_IDLE = 8'h07;
	localparam logic [7:0] FCC_CMD_SIGN = 8'h0B;
	localparam logic [7:0] FCC_CMD_PROT = 8'h0C;
	localparam logic [7:0] FCC_CMD_PING = 8'h0F;

	localparam int FCC_CLK_NS = 8;
	localparam int FCC_T_WRITE_NS = 50000;
	localparam int FCC_T_EWRITE_NS = 20000000;
	localparam int FCC_T_MASS_NS = 1200000000;
	localparam int FCC_T_SIGN_NS = 120000;
	localparam int FCC_WRITE_CYC = FCC_T_WRITE_NS / FCC_CLK_NS;
	localparam int FCC_EWRITE_CYC = FCC_T_EWRITE_NS / FCC_CLK_NS;
	localparam int FCC_MASS_CYC = FCC_T_MASS_NS / FCC_CLK_NS;
	localparam int FCC_SIGN_CYC = FCC_T_SIGN_NS / FCC_CLK_NS;
	localparam int FCC_SHORT_CYC = 1;

	typedef enum logic {FCC_IDLE, FCC_RUN} fcc_state_t;
endpackage

/* logic/fcc_tmr_if.sv */
/*
 * Carrier between the controller and its operation timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface fcc_tmr_if;
	logic start;
	logic stop;
	logic [31:0] load;
	logic done;
	modport ctl(output start, stop, load, input done);
	modport tmr(input start, stop, load, output done);
endinterface

/* logic/fcc_timer.sv */
/*
 * Down-counting operation timer: a start loads a cycle count, done
 * pulses one cycle after the count runs out, stop cancels it.
 * Assumes load is at least one and start never meets stop.
 */
`timescale 1ns/1ps
module fcc_timer
	import fcc_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	fcc_tmr_if.tmr t
);
	logic [31:0] cnt_q;
	logic run_q;
	logic done_q;
	wire logic last = run_q && (cnt_q == 32'h00000001);

	assign t.done = done_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= 32'h00000000;
			run_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= last && !t.stop;
			if (t.start) begin
				cnt_q <= t.load;
				run_q <= 1'b1;
			end else if (t.stop || last) begin
				run_q <= 1'b0;
			end else if (run_q) begin
				cnt_q <= cnt_q - 32'h00000001;
			end
		end
	end

	property p_done_cause;
		@(posedge clk_in) disable iff (!rst_n_in)
		done_q |-> $past(run_q) && $past(cnt_q) == 32'h00000001;
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("timer done without count running out");
endmodule // fcc_timer

/* logic/fcc_ctrl.sv */
/*
 * Flash command controller: APB register file with status, mode,
 * command, data and address registers; runs commands on the flash
 * array and holds the core stalled while busy.
 * Assumes the array answers on the same clock and that its read word
 * is valid while an operation is running.
 */
`timescale 1ns/1ps
// Operation
// - Command register reads idle code 0x07 once a command finishes.
// - Mass erase needs mode bit 3, address 0xFFC3, data 0x3CFF, code 0x06.
// - Status bits 15 to 4 always read as zero.
// - Reading status clears interrupt, fail and success flags.
// - Status bit 2 is high exactly while a command runs.
// - Status bit 1 sets when a command ends unsuccessfully.
// - Status bit 0 sets when a command ends successfully.
// - Status register holds 0x20 after reset.
// - Protect runs only with mode bits 6,5 written as 1,0.
// - Mode bit 4 enables the completion interrupt, clear suppresses it.
// - Mode bit 3 permits erase and write commands; clear forbids them.
// - Mode bit 1 enables aborting a running command.
// - Every command acts on the 16-bit address register.
// - Data register takes read words, supplies write words, resets 0x0000.
// - Command codes 0x01-0x07, 0x0B, 0x0C, 0x0F are decoded.
// - Core stays stalled until the running command completes or is aborted.
// - Write takes 50 us, erase-write 20 ms, busy throughout.
module fcc_ctrl
	import fcc_pkg::*;
#(
	parameter int unsigned WRITE_CYC = FCC_WRITE_CYC,
	parameter int unsigned EWRITE_CYC = FCC_EWRITE_CYC,
	parameter int unsigned PERASE_CYC = FCC_EWRITE_CYC,
	parameter int unsigned MASS_CYC = FCC_MASS_CYC,
	parameter int unsigned SIGN_CYC = FCC_SIGN_CYC,
	parameter logic [15:0] ADR_RESET = 16'h0000
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [15:0] flash_rdata_in,
	output logic flash_go_out,
	output logic flash_abort_out,
	output logic [7:0] flash_op_out,
	output logic [15:0] flash_addr_out,
	output logic [15:0] flash_wdata_out,
	output logic core_stall_out
);
	fcc_state_t st_q, st_d;
	logic [15:0] sta_q, sta_d;
	logic [6:0] mod_q;
	logic [7:0] cmd_q;
	logic [7:0] op_q;
	logic [15:0] dat_q;
	logic [15:0] adr_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, go_q, abort_q;
	fcc_tmr_if tmr_bus();

	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		return a == r;
	endfunction

	function automatic logic [31:0] cyc_of(input logic [7:0] c);
		unique case (c)
			FCC_CMD_WRITE: return 32'(WRITE_CYC);
			FCC_CMD_EWRITE: return 32'(EWRITE_CYC);
			FCC_CMD_PERASE: return 32'(PERASE_CYC);
			FCC_CMD_MASS: return 32'(MASS_CYC);
			FCC_CMD_SIGN: return 32'(SIGN_CYC);
			default: return 32'(FCC_SHORT_CYC);
		endcase
	endfunction

	// Access is answered on its second access cycle; writes land there
	wire logic acc = psel_in && penable_in && !pready_q;
	wire logic fin = psel_in && penable_in && pready_q;
	wire logic wr = fin && pwrite_in;
	wire logic rd_fin = fin && !pwrite_in;
	wire logic sel_sta = hit(paddr_in, FCC_STA_ADDR);
	wire logic sel_mod = hit(paddr_in, FCC_MOD_ADDR);
	wire logic sel_cmd = hit(paddr_in, FCC_CMD_ADDR);
	wire logic sel_dat = hit(paddr_in, FCC_DAT_ADDR);
	wire logic sel_adr = hit(paddr_in, FCC_ADR_ADDR);
	wire logic mapped = sel_sta || sel_mod || sel_cmd || sel_dat || sel_adr;
	wire logic busy = st_q == FCC_RUN;

	wire logic [7:0] code = pwdata_in[7:0];
	wire logic is_ew = code == FCC_CMD_WRITE || code == FCC_CMD_EWRITE ||
		code == FCC_CMD_PERASE || code == FCC_CMD_MASS;
	wire logic known = is_ew || code == FCC_CMD_READ ||
		code == FCC_CMD_VERIFY || code == FCC_CMD_SIGN ||
		code == FCC_CMD_PROT || code == FCC_CMD_PING;
	wire logic mass_ok = adr_q == FCC_MASS_KEY_ADR &&
		dat_q == FCC_MASS_KEY_DAT;
	wire logic lock_ok = mod_q[FCC_MOD_LOCK_HI:FCC_MOD_LOCK_LO] ==
		FCC_LOCK_KEY && mod_q[FCC_MOD_EW_EN];
	wire logic reject = !known || (is_ew && !mod_q[FCC_MOD_EW_EN]) ||
		(code == FCC_CMD_MASS && !mass_ok) ||
		(code == FCC_CMD_PROT && !lock_ok);
	wire logic cmd_wr = wr && sel_cmd && !busy && code != FCC_CMD_IDLE;
	wire logic launch = cmd_wr && !reject;
	wire logic refuse = cmd_wr && reject;
	// abort by writing idle while busy
	wire logic abort = wr && sel_cmd && busy && mod_q[FCC_MOD_ABORT] &&
		code == FCC_CMD_IDLE;
	wire logic done = busy && tmr_bus.done;
	wire logic vfy_bad = op_q == FCC_CMD_VERIFY && flash_rdata_in != dat_q;
	wire logic set_fail = refuse || abort || (done && vfy_bad);
	wire logic set_succ = done && !vfy_bad;
	wire logic set_irq = (set_fail || set_succ) && mod_q[FCC_MOD_IRQ_EN];
	// Only flags already shown to software are cleared, so an event
	// between the read capture and the clear is not lost
	wire logic [3:0] clr = rd_fin && sel_sta ? prdata_q[3:0] : 4'h0;

	assign tmr_bus.start = launch;
	assign tmr_bus.stop = abort;
	assign tmr_bus.load = cyc_of(code);

	fcc_timer u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.t(tmr_bus.tmr)
	);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			FCC_IDLE: if (launch) st_d = FCC_RUN;
			FCC_RUN: if (done || abort) st_d = FCC_IDLE;
		endcase
	end

	always_comb begin
		sta_d = sta_q;
		sta_d[FCC_STA_SUCC] = (sta_q[FCC_STA_SUCC] && !clr[FCC_STA_SUCC]) ||
			set_succ;
		sta_d[FCC_STA_FAIL] = (sta_q[FCC_STA_FAIL] && !clr[FCC_STA_FAIL]) ||
			set_fail;
		sta_d[FCC_STA_IRQ] = (sta_q[FCC_STA_IRQ] && !clr[FCC_STA_IRQ]) ||
			set_irq;
		sta_d[FCC_STA_BUSY] = st_d == FCC_RUN;
	end

	wire logic [31:0] rmux =
		sel_sta ? {16'h0000, sta_q & FCC_STA_RD_MASK} :
		sel_mod ? {25'h0000000, mod_q} :
		sel_cmd ? {24'h000000, cmd_q} :
		sel_dat ? {16'h0000, dat_q} :
		sel_adr ? {16'h0000, adr_q} : 32'h00000000;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !mapped;
			if (acc && !pwrite_in)
				prdata_q <= rmux;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= FCC_IDLE;
			sta_q <= FCC_STA_RST;
			go_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sta_q <= sta_d;
			go_q <= launch;
			abort_q <= abort;
		end
	end

	// mode bits 6 to 0 are all stored, unused bits 2 and 0 included
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			mod_q <= FCC_MOD_RST;
		else if (wr && sel_mod)
			mod_q <= pwdata_in[6:0];
	end

	// back to idle code after execution
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_q <= FCC_CMD_IDLE;
			op_q <= FCC_CMD_IDLE;
		end else if (launch) begin
			cmd_q <= code;
			op_q <= code;
		end else if (done || abort) begin
			cmd_q <= FCC_CMD_IDLE;
		end
	end

	// address and data held stable while busy
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dat_q <= FCC_DAT_RST;
			adr_q <= ADR_RESET;
		end else begin
			if (done && op_q == FCC_CMD_READ)
				dat_q <= flash_rdata_in;
			else if (wr && sel_dat && !busy)
				dat_q <= pwdata_in[15:0];
			if (wr && sel_adr && !busy)
				adr_q <= pwdata_in[15:0];
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign flash_go_out = go_q;
	assign flash_abort_out = abort_q;
	assign flash_op_out = op_q;
	assign flash_addr_out = adr_q;
	assign flash_wdata_out = dat_q;
	assign core_stall_out = sta_q[FCC_STA_BUSY];

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_idle_back;
		done |=> cmd_q == FCC_CMD_IDLE && !core_stall_out;
	endproperty
	a_idle_back: assert property (p_idle_back)
		else $error("command register not idle after completion");
	property p_mass_key;
		flash_go_out && flash_op_out == FCC_CMD_MASS |->
			flash_addr_out == FCC_MASS_KEY_ADR &&
			flash_wdata_out == FCC_MASS_KEY_DAT && mod_q[FCC_MOD_EW_EN];
	endproperty
	a_mass_key: assert property (p_mass_key)
		else $error("mass erase started without its key");
	property p_sta_high;
		rd_fin && sel_sta |-> prdata_out[31:4] == 28'h0000000;
	endproperty
	a_sta_high: assert property (p_sta_high)
		else $error("unused status bits read nonzero");
	property p_irq_gate;
		$rose(sta_q[FCC_STA_IRQ]) |-> $past(mod_q[FCC_MOD_IRQ_EN]);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt flag set while disabled");
	property p_rd_clear;
		rd_fin && sel_sta && prdata_out[FCC_STA_SUCC] && !set_succ |=>
			!sta_q[FCC_STA_SUCC];
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("success flag survived a status read");
	property p_busy_run;
		launch |=> sta_q[FCC_STA_BUSY] && core_stall_out;
	endproperty
	a_busy_run: assert property (p_busy_run)
		else $error("busy not raised by a started command");
	property p_refuse_fail;
		refuse |=> sta_q[FCC_STA_FAIL] && !flash_go_out;
	endproperty
	a_refuse_fail: assert property (p_refuse_fail)
		else $error("refused command did not fail");
	property p_reset_val;
		!$past(rst_n_in) |-> sta_q == FCC_STA_RST;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("status not at reset value");
	property p_ignore_busy;
		busy && wr && sel_cmd && !abort |=> $stable(op_q) && !flash_go_out;
	endproperty
	a_ignore_busy: assert property (p_ignore_busy)
		else $error("command accepted while busy");
endmodule // fcc_ctrl

/* verif/fcc_flash_model.sv */
/*
 * Behavioural flash array behind the command controller.
 * Assumes the controller pulses go once per operation, with op,
 * address and write word steady at that edge.
 */
`timescale 1ns/1ps
module fcc_flash_model
	import fcc_pkg::*;
(
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic [7:0] op_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out
);
	// Small array: only the low address bits select a word
	logic [15:0] mem_q [16] = '{default: 16'h0000};
	assign rdata_out = mem_q[addr_in[3:0]];
	always @(posedge clk_in) begin
		if (go_in === 1'b1) begin
			if (op_in == FCC_CMD_WRITE || op_in == FCC_CMD_EWRITE)
				mem_q[addr_in[3:0]] <= wdata_in;
			if (op_in == FCC_CMD_PERASE || op_in == FCC_CMD_MASS)
				mem_q <= '{default: 16'hFFFF};
		end
	end
endmodule // fcc_flash_model

/* verif/fcc_ctrl_test.sv */
/*
 * Self-checking bench for the flash command controller over APB.
 * Assumes one wait state per transfer and shortened operation times.
 */
`timescale 1ns/1ps
module fcc_ctrl_test;
	import fcc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, rerr, go, abort, stall;
	logic abort_seen = 1'b0;
	logic [7:0] op;
	logic [15:0] faddr, fwdata, frdata;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int go_count = 0;
	logic [7:0] codes [7] = '{8'h03, 8'h04, 8'h05, 8'h04, 8'h0B, 8'h08, 8'h01};
	logic [3:0] stat [7] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h2, 4'h1};

	always #4 clk = ~clk;

	fcc_ctrl #(.WRITE_CYC(8), .EWRITE_CYC(20), .PERASE_CYC(12),
		.MASS_CYC(30), .SIGN_CYC(10)) i_fcc_ctrl (.clk_in(clk),
		.rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.flash_rdata_in(frdata), .flash_go_out(go),
		.flash_abort_out(abort), .flash_op_out(op),
		.flash_addr_out(faddr), .flash_wdata_out(fwdata),
		.core_stall_out(stall));

	fcc_flash_model i_fcc_flash_model (.clk_in(clk), .go_in(go),
		.op_in(op), .addr_in(faddr), .wdata_in(fwdata),
		.rdata_out(frdata));

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Waits for the answer; only the bench timeout ends a hang
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		chk("wait states", 32'h2, 32'(n));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [31:0] a, exp, input string name);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rdat);
	endtask

	// Waits out a running command, bounded well above any shortened time
	task automatic idle;
		int n;
		n = 0;
		while (stall === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("stall released", 32'h0, {31'h0, stall});
	endtask

	task automatic cmd(input logic [7:0] code, input logic [3:0] exp);
		apb(1'b1, FCC_CMD_ADDR, {24'h0, code});
		idle();
		rd(FCC_STA_ADDR, {28'h0, exp}, "status");
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (abort === 1'b1)
			abort_seen <= 1'b1;
		if (go === 1'b1)
			go_count <= go_count + 1;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(FCC_STA_ADDR, 32'h0, "status reset");
		rd(FCC_MOD_ADDR, 32'h0, "mode reset");
		rd(FCC_CMD_ADDR, 32'h7, "command reset");
		chk("mapped error", 32'h0, {31'h0, rerr});
		rd(FCC_DAT_ADDR, 32'h0, "data reset");
		rd(32'hFFFF0E14, 32'h0, "unmapped");
		chk("unmapped error", 32'h1, {31'h0, rerr});
		apb(1'b1, FCC_ADR_ADDR, 32'h3);
		chk("flash address", 32'h3, {16'h0, faddr});
		apb(1'b1, FCC_DAT_ADDR, 32'hA5A5);
		cmd(FCC_CMD_WRITE, 4'h2);
		rd(FCC_STA_ADDR, 32'h0, "status cleared");
		cmd(FCC_CMD_READ, 4'h1);
		rd(FCC_DAT_ADDR, 32'h0, "array untouched");
		apb(1'b1, FCC_MOD_ADDR, 32'h08);
		apb(1'b1, FCC_DAT_ADDR, 32'hA5A5);
		apb(1'b1, FCC_CMD_ADDR, {24'h0, FCC_CMD_WRITE});
		rd(FCC_STA_ADDR, 32'h4, "busy");
		chk("core stall", 32'h1, {31'h0, stall});
		apb(1'b1, FCC_CMD_ADDR, 32'h0);
		idle();
		rd(FCC_STA_ADDR, 32'h1, "write done");
		rd(FCC_CMD_ADDR, 32'h7, "command idle");
		apb(1'b1, FCC_DAT_ADDR, 32'h0);
		cmd(FCC_CMD_READ, 4'h1);
		rd(FCC_DAT_ADDR, 32'hA5A5, "read word");
		apb(1'b1, FCC_MOD_ADDR, 32'h18);
		apb(1'b1, FCC_ADR_ADDR, 32'h0);
		cmd(FCC_CMD_MASS, 4'hA);
		cmd(FCC_CMD_PING, 4'h9);
		apb(1'b1, FCC_MOD_ADDR, 32'h08);
		apb(1'b1, FCC_ADR_ADDR, {16'h0, FCC_MASS_KEY_ADR});
		apb(1'b1, FCC_DAT_ADDR, {16'h0, FCC_MASS_KEY_DAT});
		cmd(FCC_CMD_MASS, 4'h1);
		apb(1'b1, FCC_ADR_ADDR, 32'h3);
		cmd(FCC_CMD_READ, 4'h1);
		rd(FCC_DAT_ADDR, 32'hFFFF, "erased word");
		cmd(FCC_CMD_PROT, 4'h2);
		apb(1'b1, FCC_MOD_ADDR, 32'h48);
		cmd(FCC_CMD_PROT, 4'h1);
		apb(1'b1, FCC_MOD_ADDR, 32'h08);
		apb(1'b1, FCC_DAT_ADDR, 32'h5A5A);
		for (int i = 0; i < 7; i++) begin
			cmd(codes[i], stat[i]);
		end
		rd(FCC_DAT_ADDR, 32'hFFFF, "read after erase");
		apb(1'b1, FCC_MOD_ADDR, 32'h0A);
		apb(1'b1, FCC_CMD_ADDR, {24'h0, FCC_CMD_EWRITE});
		apb(1'b1, FCC_CMD_ADDR, {24'h0, FCC_CMD_IDLE});
		idle();
		rd(FCC_STA_ADDR, 32'h2, "aborted");
		chk("abort pulse", 32'h1, {31'h0, abort_seen});
		// Fourteen accepted commands; refused and ignored ones start nothing
		chk("go pulses", 32'h0000000E, 32'(go_count));
		test_done();
	end
endmodule // fcc_ctrl_test
